// >>> core/fpio_channels.sv
// pulse input totalizer/rate filter and multi-mode digital output channel
// Notes on behaviour
// - input total scaled by K-factor, either sense
// - rate from 500 ms windows is filtered
// - zero filter constant passes rate unfiltered
// - two constants, fraction between zero and one
// - pulse count follows selected stream total
// - output bound to one stream 1..12
// - quantity: base, line volume, mass, energy
// - output K-factor pulses/unit or units/pulse
// - pulse high for length times 10 ms
// - gap low at least gap times 10 ms
// - rate alarm on selected limit event
// - fault alarm follows stream fault state
// - analogue alarm on selected limit flag
// - digital alarm follows selected input alarm
// - common alarm follows general process alarm
// - time base emits periodic pulses
// - batch mode follows stream batching control
//
// Our own choices: the address-and-strobe port and the register addresses.
module fpio_channels
  import fpio_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned CALC_CYCLES = CALC_CYC,
  parameter int unsigned SEC_CYCLES  = SEC_CYC
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_q,
  // field inputs
  input  wire logic        pulse_contact,
  input  wire logic [11:0] base_volume_tick,
  input  wire logic [11:0] line_volume_tick,
  input  wire logic [11:0] mass_tick,
  input  wire logic [11:0] energy_total_tick,
  input  wire logic [11:0] rate_lo,
  input  wire logic [11:0] rate_hi,
  input  wire logic [11:0] rate_lolo,
  input  wire logic [11:0] rate_hihi,
  input  wire logic [11:0] stream_fault_alarm,
  input  wire logic [11:0] batch_load,
  input  wire logic [23:0] ai_flags,
  input  wire logic [7:0]  di_alarm,
  input  wire logic        common_alarm,
  // contact output
  output logic             out_pin_q
);
  typedef enum logic [1:0] {P_IDLE = 2'b00, P_HIGH = 2'b01, P_GAP = 2'b10} fpio_pst_t;

  // pick the bit of a stream vector; numbers outside 1..12 select nothing
  function automatic logic strm_bit(input logic [11:0] v, input logic [3:0] n);
    strm_bit = (n >= 4'h1 && n <= 4'hC) ? v[n - 4'h1] : 1'b0;
  endfunction

  // first order low pass step, constant k is a 16-bit fraction
  function automatic logic signed [31:0] filt(input logic signed [31:0] prev,
                                              input logic signed [31:0] raw,
                                              input logic [15:0] k);
    logic signed [47:0] p;
    p = 48'(raw - prev) * 48'($signed({1'b0, k}));
    filt = (k == 16'h0000) ? raw : prev + 32'(p >>> 16);
  endfunction

  logic [2:0]       in_ctrl_q;
  logic [15:0]      in_kfac_q, filt1_q, filt2_q, out_kfac_q;
  logic [OC_W-1:0]  out_ctrl_q;
  logic [7:0]       len_q, gap_q, delay_q, tb_per_q, tb_len_q;

  // register writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      in_ctrl_q  <= RST_CTRL[2:0];
      in_kfac_q  <= RST_KFAC;
      filt1_q    <= 16'h0000;
      filt2_q    <= 16'h0000;
      out_ctrl_q <= RST_CTRL;
      out_kfac_q <= RST_KFAC;
      len_q      <= RST_TICKS;
      gap_q      <= RST_TICKS;
      delay_q    <= 8'h00;
      tb_per_q   <= 8'h00;
      tb_len_q   <= 8'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        REG_IN_CTRL:  in_ctrl_q  <= reg_wdata[2:0];
        REG_IN_KFAC:  in_kfac_q  <= reg_wdata[15:0];
        REG_FILT1:    filt1_q    <= reg_wdata[15:0];
        REG_FILT2:    filt2_q    <= reg_wdata[15:0];
        REG_OUT_CTRL: out_ctrl_q <= reg_wdata[OC_W-1:0];
        REG_OUT_KFAC: out_kfac_q <= reg_wdata[15:0];
        REG_TIMING:
        begin
          len_q <= reg_wdata[7:0];
          gap_q <= reg_wdata[15:8];
        end
        REG_DELAY:    delay_q    <= reg_wdata[7:0];
        REG_TBASE:
        begin
          tb_per_q <= reg_wdata[7:0];
          tb_len_q <= reg_wdata[15:8];
        end
        default:      ;
      endcase
    end
  end

  // field decode
  logic       in_act, in_nc, out_act, out_nc, out_kmode;
  fpio_mode_t mode;
  logic [3:0] strm;
  logic [1:0] qty;
  logic [2:0] evt, sel;
  assign in_act    = in_ctrl_q[CTL_ACT];
  assign in_nc     = in_ctrl_q[CTL_NC];
  assign out_act   = out_ctrl_q[CTL_ACT];
  assign out_nc    = out_ctrl_q[CTL_NC];
  assign out_kmode = out_ctrl_q[CTL_KMODE];
  assign mode      = fpio_mode_t'(out_ctrl_q[OC_MODE +: 3]);
  assign strm      = out_ctrl_q[OC_STRM +: 4];
  assign qty       = out_ctrl_q[OC_QTY +: 2];
  assign evt       = out_ctrl_q[OC_EVT +: 3];
  assign sel       = out_ctrl_q[OC_SEL +: 3];

  // shared timebases: 500 ms calculation cycle and 1 s
  logic [31:0] calc_cnt_q, sec_cnt_q;
  logic        calc_stb, sec_stb;
  assign calc_stb = (calc_cnt_q == CALC_CYCLES - 1);
  assign sec_stb  = (sec_cnt_q == SEC_CYCLES - 1);
  always_ff @(posedge ref_clk)
  begin
    if (rst || calc_stb) calc_cnt_q <= 32'h0;
    else calc_cnt_q <= calc_cnt_q + 32'h1;
    if (rst || sec_stb) sec_cnt_q <= 32'h0;
    else sec_cnt_q <= sec_cnt_q + 32'h1;
  end

  // input contact edge detect with contact sense
  logic in_lvl, in_prev_q, in_edge;
  assign in_lvl  = pulse_contact ^ in_nc;
  assign in_edge = in_act && in_lvl && !in_prev_q;
  always_ff @(posedge ref_clk)
  begin
    if (rst) in_prev_q <= 1'b0;
    else in_prev_q <= in_lvl;
  end

  // totalizer: pulses per unit divides, units per pulse multiplies
  logic [15:0] div_q;
  logic [31:0] inc, total_q, win_q;
  logic        div_wrap;
  assign div_wrap = (div_q + 16'h1 >= in_kfac_q);
  always_comb
  begin
    inc = 32'h0;
    if (in_edge)
      inc = in_ctrl_q[CTL_KMODE] ? {16'h0, in_kfac_q} : {31'h0, div_wrap};
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_q   <= 16'h0;
      total_q <= 32'h0;
      win_q   <= 32'h0;
    end
    else
    begin
      if (in_edge && !in_ctrl_q[CTL_KMODE]) div_q <= div_wrap ? 16'h0 : div_q + 16'h1;
      total_q <= total_q + inc;
      win_q   <= calc_stb ? inc : win_q + inc;
    end
  end

  // two cascaded filter stages updated each calculation cycle
  logic signed [31:0] raw, rate1_q, rate2_q, rate1_d;
  assign raw     = $signed(win_q << RATE_FRAC);
  assign rate1_d = filt(rate1_q, raw, filt1_q);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rate1_q <= 32'sh0;
      rate2_q <= 32'sh0;
    end
    else if (calc_stb)
    begin
      rate1_q <= rate1_d;
      rate2_q <= filt(rate2_q, rate1_d, filt2_q);
    end
  end

  // selected stream quantity increment
  logic unit_tick;
  always_comb
  begin
    case (qty)
      QTY_BASE: unit_tick = strm_bit(base_volume_tick, strm);
      QTY_LINE: unit_tick = strm_bit(line_volume_tick, strm);
      QTY_MASS: unit_tick = strm_bit(mass_tick, strm);
      default:  unit_tick = strm_bit(energy_total_tick, strm);
    endcase
  end

  // pending output pulses from stream increments
  fpio_pst_t   pst_q;
  logic [31:0] pend_q, add, dur_q, len_cyc, gap_cyc;
  logic [15:0] odiv_q;
  logic        pulse_on, start, odiv_wrap;
  assign pulse_on  = out_act && (mode == MD_PULSE);
  assign odiv_wrap = (odiv_q + 16'h1 >= out_kfac_q);
  assign start     = pulse_on && (pst_q == P_IDLE) && (pend_q != 32'h0);
  always_comb
  begin
    add = 32'h0;
    if (pulse_on && unit_tick)
      add = out_kmode ? {31'h0, odiv_wrap} : {16'h0, out_kfac_q};
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || !pulse_on)
    begin
      pend_q <= 32'h0;
      odiv_q <= 16'h0;
    end
    else
    begin
      pend_q <= pend_q + add - {31'h0, start};
      if (unit_tick && out_kmode) odiv_q <= odiv_wrap ? 16'h0 : odiv_q + 16'h1;
    end
  end

  // pulse length and gap timing; zero counts act as one tick
  assign len_cyc = ((len_q == 8'h0) ? 32'h1 : {24'h0, len_q}) * TICK_CYCLES;
  assign gap_cyc = ((gap_q == 8'h0) ? 32'h1 : {24'h0, gap_q}) * TICK_CYCLES;
  always_ff @(posedge ref_clk)
  begin
    if (rst || !pulse_on)
    begin
      pst_q <= P_IDLE;
      dur_q <= 32'h0;
    end
    else
    begin
      case (pst_q)
        P_IDLE:
        begin
          dur_q <= 32'h0;
          if (start) pst_q <= P_HIGH;
        end
        P_HIGH:
        begin
          // compare with >= so a length shortened mid-pulse cannot run the counter away
          dur_q <= (dur_q >= len_cyc - 1) ? 32'h0 : dur_q + 32'h1;
          if (dur_q >= len_cyc - 1) pst_q <= P_GAP;
        end
        P_GAP:
        begin
          dur_q <= dur_q + 32'h1;
          if (dur_q >= gap_cyc - 1) pst_q <= P_IDLE;
        end
        default: pst_q <= P_IDLE;
      endcase
    end
  end

  // alarm source selection
  logic cond;
  always_comb
  begin
    case (mode)
      MD_RATE:
        case (evt)
          EVT_LO:   cond = strm_bit(rate_lo, strm);
          EVT_HI:   cond = strm_bit(rate_hi, strm);
          EVT_LOLO: cond = strm_bit(rate_lolo, strm);
          EVT_HIHI: cond = strm_bit(rate_hihi, strm);
          default:  cond = 1'b0;
        endcase
      MD_FAULT:  cond = strm_bit(stream_fault_alarm, strm);
      MD_AI:     cond = (evt < 3'h6) && ai_flags[{3'h0, sel[1:0]} * 5'h06 + {2'h0, evt}];
      MD_DI:     cond = di_alarm[sel];
      MD_COMMON: cond = common_alarm;
      default:   cond = 1'b0;
    endcase
  end

  // persistence delay in whole seconds and time base second counter
  logic [7:0] al_sec_q, tb_sec_q;
  logic       al_on;
  assign al_on = cond && (delay_q == 8'h0 || al_sec_q >= delay_q);
  always_ff @(posedge ref_clk)
  begin
    if (rst || !cond) al_sec_q <= 8'h0;
    else if (sec_stb && al_sec_q != 8'hFF) al_sec_q <= al_sec_q + 8'h1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || mode != MD_TBASE) tb_sec_q <= 8'h0;
    else if (sec_stb) tb_sec_q <= (tb_sec_q + 8'h1 >= tb_per_q) ? 8'h0 : tb_sec_q + 8'h1;
  end

  // logical output level per mode, then contact sense
  logic lvl;
  always_comb
  begin
    case (mode)
      MD_PULSE: lvl = (pst_q == P_HIGH);
      MD_TBASE: lvl = (tb_per_q != 8'h0) && (tb_sec_q < tb_len_q);
      MD_BATCH: lvl = strm_bit(batch_load, strm);
      default:  lvl = al_on;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst) out_pin_q <= 1'b0;
    else out_pin_q <= out_act ? (lvl ^ out_nc) : out_nc;
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst || !reg_rd) reg_rdata_q <= 32'h0;
    else
      case (reg_addr)
        REG_IN_CTRL:  reg_rdata_q <= {29'h0, in_ctrl_q};
        REG_IN_KFAC:  reg_rdata_q <= {16'h0, in_kfac_q};
        REG_FILT1:    reg_rdata_q <= {16'h0, filt1_q};
        REG_FILT2:    reg_rdata_q <= {16'h0, filt2_q};
        REG_TOTAL:    reg_rdata_q <= total_q;
        REG_RATE:     reg_rdata_q <= rate2_q;
        REG_OUT_CTRL: reg_rdata_q <= {14'h0, out_ctrl_q};
        REG_OUT_KFAC: reg_rdata_q <= {16'h0, out_kfac_q};
        REG_TIMING:   reg_rdata_q <= {16'h0, gap_q, len_q};
        REG_DELAY:    reg_rdata_q <= {24'h0, delay_q};
        REG_TBASE:    reg_rdata_q <= {16'h0, tb_len_q, tb_per_q};
        REG_STATUS:   reg_rdata_q <= {pend_q[15:0], 12'h0, al_on, lvl, pst_q};
        default:      reg_rdata_q <= 32'h0;
      endcase
  end

  // checks
  property p_idle_pin;
    @(posedge ref_clk) disable iff (rst) !out_act |=> (out_pin_q == $past(out_nc));
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("inactive output not deasserted");
  property p_len;
    @(posedge ref_clk) disable iff (rst) (pst_q == P_HIGH && pulse_on) |-> (dur_q < len_cyc);
  endproperty
  a_len: assert property (p_len) else $error("pulse longer than length");
  property p_gap;
    @(posedge ref_clk) disable iff (rst)
      (pst_q == P_GAP && pulse_on && dur_q < gap_cyc - 1) |=> (pst_q == P_GAP || !$past(pulse_on));
  endproperty
  a_gap: assert property (p_gap) else $error("gap ended early");
  property p_bypass;
    @(posedge ref_clk) disable iff (rst) (calc_stb && filt1_q == 16'h0) |=> (rate1_q == $past(raw));
  endproperty
  a_bypass: assert property (p_bypass) else $error("zero constant did not bypass");
  property p_upp;
    @(posedge ref_clk) disable iff (rst)
      (in_edge && in_ctrl_q[CTL_KMODE]) |=> (total_q == $past(total_q) + {16'h0, $past(in_kfac_q)});
  endproperty
  a_upp: assert property (p_upp) else $error("total not scaled by K-factor");
  property p_pend;
    @(posedge ref_clk) disable iff (rst)
      (pulse_on && unit_tick && !out_kmode && !start) ##1 pulse_on
        |-> (pend_q == $past(pend_q) + {16'h0, $past(out_kfac_q)});
  endproperty
  a_pend: assert property (p_pend) else $error("pending pulses not increased");
  property p_fault_now;
    @(posedge ref_clk) disable iff (rst)
      (out_act && !out_nc && mode == MD_FAULT && delay_q == 8'h0 && cond) |=> out_pin_q;
  endproperty
  a_fault_now: assert property (p_fault_now) else $error("zero delay alarm not immediate");
  property p_in_idle;
    @(posedge ref_clk) disable iff (rst) !in_act |=> (total_q == $past(total_q));
  endproperty
  a_in_idle: assert property (p_in_idle) else $error("inactive input counted");
endmodule

// >>> core/fpio_pkg.sv
// constants shared by the flow pulse input / digital output channel block
package fpio_pkg;
  // register byte offsets
  localparam logic [5:0] REG_IN_CTRL  = 6'h00;
  localparam logic [5:0] REG_IN_KFAC  = 6'h04;
  localparam logic [5:0] REG_FILT1    = 6'h08;
  localparam logic [5:0] REG_FILT2    = 6'h0C;
  localparam logic [5:0] REG_TOTAL    = 6'h10;
  localparam logic [5:0] REG_RATE     = 6'h14;
  localparam logic [5:0] REG_OUT_CTRL = 6'h18;
  localparam logic [5:0] REG_OUT_KFAC = 6'h1C;
  localparam logic [5:0] REG_TIMING   = 6'h20;
  localparam logic [5:0] REG_DELAY    = 6'h24;
  localparam logic [5:0] REG_TBASE    = 6'h28;
  localparam logic [5:0] REG_STATUS   = 6'h2C;
  // control field positions (both channels share bits 0..2)
  localparam int CTL_ACT   = 0;
  localparam int CTL_NC    = 1;
  localparam int CTL_KMODE = 2;
  localparam int OC_MODE   = 3;
  localparam int OC_STRM   = 6;
  localparam int OC_QTY    = 10;
  localparam int OC_EVT    = 12;
  localparam int OC_SEL    = 15;
  localparam int OC_W      = 18;
  // reset values
  localparam logic [OC_W-1:0] RST_CTRL = 18'h00000;
  localparam logic [15:0] RST_KFAC = 16'h0001;
  localparam logic [7:0]  RST_TICKS = 8'h01;
  // output modes
  typedef enum logic [2:0] {
    MD_PULSE = 3'b000, MD_RATE = 3'b001, MD_FAULT = 3'b010, MD_AI = 3'b011,
    MD_DI = 3'b100, MD_COMMON = 3'b101, MD_TBASE = 3'b110, MD_BATCH = 3'b111
  } fpio_mode_t;
  // stream quantity and rate event selections
  localparam logic [1:0] QTY_BASE = 2'h0;
  localparam logic [1:0] QTY_LINE = 2'h1;
  localparam logic [1:0] QTY_MASS = 2'h2;
  localparam logic [2:0] EVT_LO   = 3'h1;
  localparam logic [2:0] EVT_HI   = 3'h2;
  localparam logic [2:0] EVT_LOLO = 3'h3;
  localparam logic [2:0] EVT_HIHI = 3'h4;
  // timing
  localparam int unsigned CLK_HZ  = 10_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned CALC_MS = 500;
  localparam int unsigned SEC_MS  = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned CALC_CYC = CLK_HZ / 1000 * CALC_MS;
  localparam int unsigned SEC_CYC  = CLK_HZ / 1000 * SEC_MS;
  localparam int RATE_FRAC = 8;
endpackage

// >>> sim/fpio_field.sv
// flow meter contact model: square pulse train while running, open contact at rest
module fpio_field (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // pulse train control
  input  wire logic       run,
  input  wire logic [7:0] half,
  // contact
  output logic            pulse_contact
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  // toggle every half period; an idle meter leaves the contact open (low)
  always_ff @(posedge ref_clk)
  begin
    if (rst || !run)
    begin
      cnt_q         <= 8'h00;
      pulse_contact <= 1'b0;
    end
    else if (cnt_q >= half - 8'h01)
    begin
      cnt_q         <= 8'h00;
      pulse_contact <= ~pulse_contact;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end
endmodule

// >>> sim/test_flow_pulse_io_channels.sv
// self-checking bench for the pulse input and digital output channel block
module test_flow_pulse_io_channels
  import fpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata_q;
  logic        pulse_contact;
  logic [11:0] base_volume_tick = '0, line_volume_tick = '0, mass_tick = '0, energy_total_tick = '0;
  logic [11:0] rate_lo = '0, rate_hi = '0, rate_lolo = '0, rate_hihi = '0, stream_fault_alarm = '0, batch_load = '0;
  logic [23:0] ai_flags = '0;
  logic [7:0]  di_alarm = '0, half = 8'h05;
  logic        common_alarm = 1'b0, run = 1'b0, out_pin_q, pin_prev = 1'b0, nc;
  int          n_errors = 0, n_checks = 0, cyc = 0, run_len = 0, n_rise = 0, bad_hi = 0, last_lo = 0, exp_hi = 0;
  int          i, s, q, k, n, t0, r0, b0;
  logic [2:0]  md, ev, sel;
  logic [31:0] d;
  logic [2:0]  mds [5] = '{MD_FAULT, MD_AI, MD_DI, MD_COMMON, MD_BATCH};

  // clock generator, 100 ns period
  always #50 ref_clk = ~ref_clk;

  // device with shortened tick, window and second counts
  fpio_channels #(.TICK_CYCLES(4), .CALC_CYCLES(40), .SEC_CYCLES(20)) i_dut (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .pulse_contact,
    .base_volume_tick, .line_volume_tick, .mass_tick, .energy_total_tick, .rate_lo, .rate_hi,
    .rate_lolo, .rate_hihi, .stream_fault_alarm, .batch_load, .ai_flags, .di_alarm, .common_alarm, .out_pin_q
  );

  // flow meter on the contact input
  fpio_field i_field (.ref_clk, .rst, .run, .half, .pulse_contact);

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic waitc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  // one-cycle register write
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
  endtask

  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(nm, v, e);
  endtask

  // exactly p contact closures from the meter
  task automatic pulses(input int p);
    half <= 8'h05;
    run  <= 1'b1;
    waitc(10 * p + 2);
    run <= 1'b0;
    waitc(3);
  endtask

  // one unit of total increase on stream st, quantity qt
  task automatic tick(input int st, input int qt);
    @(posedge ref_clk);
    case (qt)
      0: base_volume_tick <= 12'h001 << (st - 1);
      1: line_volume_tick <= 12'h001 << (st - 1);
      2: mass_tick <= 12'h001 << (st - 1);
      default: energy_total_tick <= 12'h001 << (st - 1);
    endcase
    @(posedge ref_clk);
    {base_volume_tick, line_volume_tick, mass_tick, energy_total_tick} <= '0;
  endtask

  // raise or drop the condition selected by md, ev, sel and s
  task automatic setc(input logic v);
    logic [11:0] sb;
    sb = v ? 12'h001 << (s - 1) : 12'h000;
    case (md)
      3'd1:
      begin
        rate_lo   <= (ev == 3'd1 || ev == 3'd0) ? sb : '0;
        rate_hi   <= (ev == 3'd2 || ev == 3'd0) ? sb : '0;
        rate_lolo <= (ev == 3'd3 || ev == 3'd0) ? sb : '0;
        rate_hihi <= (ev == 3'd4 || ev == 3'd0) ? sb : '0;
      end
      3'd2: stream_fault_alarm <= sb;
      3'd3: ai_flags <= v ? 24'h000001 << (sel[1:0] * 6 + ev) : '0;
      3'd4: di_alarm <= v ? 8'h01 << sel : '0;
      3'd5: common_alarm <= v;
      default: batch_load <= sb;
    endcase
  endtask

  // cycle ceiling against hangs
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      close_out();
    end
  end

  // contact output monitor: high lengths, rises and the low run before each rise
  always @(posedge ref_clk)
  begin
    if (out_pin_q !== pin_prev)
    begin
      if (pin_prev && run_len != exp_hi)
        bad_hi++;
      if (out_pin_q)
      begin
        n_rise++;
        last_lo = run_len;
      end
      run_len = 0;
    end
    run_len++;
    pin_prev = out_pin_q;
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h394d));
    waitc(10);
    rst <= 1'b0;
    rchk("in_kfac", REG_IN_KFAC, 32'h1);
    rchk("out_kfac", REG_OUT_KFAC, 32'h1);
    rchk("timing", REG_TIMING, 32'h101);
    rchk("unmapped", 6'h30, 32'h0);
    wr(REG_TOTAL, 32'hFFFF);
    rchk("total_ro", REG_TOTAL, 32'h0);
    wr(REG_IN_CTRL, 32'hFFFFFFFF);
    rchk("in_ctrl", REG_IN_CTRL, 32'h7);
    // open contact read through a closed-at-rest sense is one edge, K=1 units per pulse
    rchk("tot_nc0", REG_TOTAL, 32'h1);
    chk("pin_rst", out_pin_q, 1'b0);
    // input totalizer in both K-factor senses, inactive and inverted contact
    wr(REG_IN_KFAC, 32'h3);
    wr(REG_IN_CTRL, 32'h1);
    pulses(6);
    rchk("tot_ppu", REG_TOTAL, 32'h3);
    k = $urandom_range(9, 1);
    n = $urandom_range(6, 2);
    wr(REG_IN_KFAC, k);
    wr(REG_IN_CTRL, 32'h5);
    rd(REG_TOTAL, d);
    t0 = d;
    pulses(n);
    rchk("tot_upp", REG_TOTAL, t0 + n * k);
    wr(REG_IN_CTRL, 32'h4);
    pulses(n);
    rchk("tot_off", REG_TOTAL, t0 + n * k);
    wr(REG_IN_CTRL, 32'h7);
    waitc(2);
    rd(REG_TOTAL, d);
    t0 = d;
    pulses(n);
    rchk("tot_nc", REG_TOTAL, t0 + n * k);
    // rate: bypass, two filter stages after a step, bypass again
    wr(REG_IN_KFAC, 32'h1);
    wr(REG_IN_CTRL, 32'h5);
    wr(REG_FILT1, 32'h0);
    wr(REG_FILT2, 32'h0);
    run <= 1'b1;
    waitc(130);
    rchk("rate_raw", REG_RATE, 32'h400);
    wr(REG_FILT1, 32'h8000);
    wr(REG_FILT2, 32'h8000);
    half <= 8'h0A;
    waitc(70);
    rd(REG_RATE, d);
    chk("rate_filt", d > 32'h200 && d < 32'h400, 1'b1);
    wr(REG_FILT1, 32'h0);
    wr(REG_FILT2, 32'h0);
    waitc(130);
    rchk("rate_byp", REG_RATE, 32'h200);
    run <= 1'b0;
    // pulse output, pulses per unit then units per pulse of three
    s = $urandom_range(12, 1);
    q = $urandom_range(3);
    k = $urandom_range(3, 1);
    n = $urandom_range(3, 1);
    exp_hi = k * 4;
    wr(REG_TIMING, (n << 8) | k);
    wr(REG_OUT_KFAC, 32'h2);
    wr(REG_OUT_CTRL, (q << 10) | (s << 6) | 1);
    r0 = n_rise;
    b0 = bad_hi;
    tick(s, q);
    waitc(80);
    chk("n_pulse", n_rise - r0, 2);
    chk("hi_len", bad_hi - b0, 0);
    chk("gap", last_lo >= n * 4, 1'b1);
    wr(REG_OUT_KFAC, 32'h3);
    wr(REG_OUT_CTRL, (q << 10) | (s << 6) | 5);
    r0 = n_rise;
    for (i = 0; i < 3; i++)
      tick(s, q);
    tick(s, (q + 1) % 4);
    tick(s % 12 + 1, q);
    waitc(80);
    chk("n_upp", n_rise - r0, 1);
    rchk("status", REG_STATUS, 32'h0);
    // every alarm mode and rate event, random contact sense
    wr(REG_DELAY, 32'h0);
    for (i = 0; i < 10; i++)
    begin
      md = (i < 5) ? 3'd1 : mds[i - 5];
      ev = (i < 5) ? 3'(i) : 3'($urandom_range(5));
      sel = $urandom_range(7);
      nc = (i == 5) ? 1'b0 : 1'($urandom_range(1)); // open-at-rest fault case always seen
      s = $urandom_range(12, 1);
      wr(REG_OUT_CTRL, {sel, ev, 2'b00, 4'(s), md, 1'b0, nc, 1'b1});
      waitc(2);
      chk("alm_idle", out_pin_q, nc);
      setc(1'b1);
      waitc(3);
      chk("alm_on", out_pin_q, (md != 3'd1 || ev != 3'd0) ^ nc);
      setc(1'b0);
      waitc(3);
      chk("alm_off", out_pin_q, nc);
    end
    // two-second delay on the common alarm
    wr(REG_DELAY, 32'h2);
    wr(REG_OUT_CTRL, 32'h29);
    common_alarm <= 1'b1;
    waitc(15);
    chk("dly_early", out_pin_q, 1'b0);
    waitc(30);
    chk("dly_late", out_pin_q, 1'b1);
    // inactive channel with closed-at-rest contact
    wr(REG_OUT_CTRL, 32'h2A);
    waitc(4);
    chk("inact", out_pin_q, 1'b1);
    common_alarm <= 1'b0;
    // time base: 2 s period, 1 s pulse, ten seconds observed
    wr(REG_TBASE, 32'h0102);
    wr(REG_OUT_CTRL, 32'h31);
    r0 = n_rise;
    waitc(200);
    chk("tbase", (n_rise - r0) inside {[4:6]}, 1'b1);
    close_out();
  end
endmodule
